// ### core/reset_and_clock_sequencer.v
// Reset phasing and system clock derivation for the integration unit
`timescale 1ns/1ps
`include "rst_clk_seq_defines.vh"
module reset_and_clock_sequencer (
    input wire SYSTEM_CLOCK,
    input wire RSTN,
    input wire POR_N,
    input wire EXT_RST_N,
    input wire SW_RST_REQ,
    input wire WDOG_RST_N,
    input wire MASTER_OSC_IN,
    input wire PLL_CLK_IN,
    input wire CLK_SRC_SEL,
    input wire PLL_POWERED,
    input wire TIMER_FAST_SEL,
    input wire PWM_FAST_SEL,
    input wire HOLDOFF_REQ,
    input wire WAIT_MODE,
    input wire STOP_MODE,
    input wire CORE_CLK_DIS,
    input wire PERIPH_CLK_DIS,
    output wire JTAG_RST_N,
    output wire EXT_POR_N,
    output wire CLK_GEN_RST_N,
    output wire PERIPH_RST_N,
    output wire CORE_RST_N,
    output wire FAST_CLK,
    output wire X2_CLK,
    output wire BUS_CLK,
    output wire BUS_CLK_DLY,
    output wire CORE_CLK,
    output wire MEM_CLK,
    output wire PERIPH_CLK,
    output wire ADC_BUS_CLK,
    output wire TIMER_CLK,
    output wire PWM_CLK
);
    localparam [`PHASE_W-1:0] PH_HOLD = 3'h0;
    localparam [`PHASE_W-1:0] PH_CLKGEN = 3'h1;
    localparam [`PHASE_W-1:0] PH_PERIPH = 3'h2;
    localparam [`PHASE_W-1:0] PH_CORE = 3'h3;
    localparam [`PHASE_W-1:0] PH_RUN = 3'h4;

    // Saturating count toward a limit
    function [`CNT_W-1:0] sat_inc;
        input [`CNT_W-1:0] val;
        input [`CNT_W-1:0] lim;
        begin
            sat_inc = (val == lim) ? lim : val + 7'h01;
        end
    endfunction

    // Timer or PWM clock choice: triple rate only when allowed
    function pick_clk;
        input fast_sel;
        input hs_ok;
        input fast_clk;
        input bus_clk;
        begin
            pick_clk = (fast_sel & hs_ok) ? fast_clk : bus_clk;
        end
    endfunction

    wire por_s;
    wire ext_s;
    wire arst_n;
    wire por_arst_n;
    wire comb_rst_n;
    wire osc_rise;
    wire osc_fall;
    wire pll_rise;
    wire pll_edge;
    wire pll_sel;
    wire hs_ok;
    wire bus_rise;
    wire dly_fall;
    wire core_run;
    wire periph_run;

    reg osc_q;
    reg osc_prev_q;
    reg pll_q;
    reg pll_prev_q;
    reg [`CNT_W-1:0] ext_cnt_q;
    reg ext_por_n_q;
    reg [`PHASE_W-1:0] ph_q;
    reg [`PHASE_W-1:0] ph_d;
    reg [`CNT_W-1:0] cnt_q;
    reg [`CNT_W-1:0] cnt_d;
    reg clkgen_q;
    reg clkgen_d;
    reg periph_q;
    reg periph_d;
    reg core_q;
    reg core_d;
    reg fast_q;
    reg [`DIV3_W-1:0] div3_q;
    reg x2_q;
    reg x2_prev_q;
    reg bus_q;
    reg bus_dly_q;
    reg dly_prev_q;
    reg core_en_q;
    reg periph_en_q;
    reg core_clk_q;
    reg periph_clk_q;
    reg timer_clk_q;
    reg pwm_clk_q;

    reset_sync u_por_sync (
        .clk(SYSTEM_CLOCK),
        .arst_n(RSTN & POR_N),
        .rst_n_out(por_s)
    );

    reset_sync u_ext_sync (
        .clk(SYSTEM_CLOCK),
        .arst_n(RSTN & EXT_RST_N),
        .rst_n_out(ext_s)
    );

    assign arst_n = por_s & ext_s;
    assign por_arst_n = por_s;
    assign comb_rst_n = arst_n & WDOG_RST_N & ~SW_RST_REQ;

    // test access reset from power-on or RSTN only
    assign JTAG_RST_N = por_s;

    // Sample the oscillator and PLL clocks as plain levels
    always @(posedge SYSTEM_CLOCK or negedge RSTN) begin
        if (!RSTN) begin
            osc_q <= `CLK_LOW;
            osc_prev_q <= `CLK_LOW;
            pll_q <= `CLK_LOW;
            pll_prev_q <= `CLK_LOW;
        end else begin
            osc_q <= MASTER_OSC_IN;
            osc_prev_q <= osc_q;
            pll_q <= PLL_CLK_IN;
            pll_prev_q <= pll_q;
        end
    end

    // oscillator edges seen even during reset
    assign osc_rise = osc_q & ~osc_prev_q;
    assign osc_fall = ~osc_q & osc_prev_q;
    assign pll_rise = pll_q & ~pll_prev_q;
    assign pll_edge = pll_q ^ pll_prev_q;

    // power-on stretch, restarted by any new power-on
    always @(posedge SYSTEM_CLOCK or negedge por_arst_n) begin
        if (!por_arst_n) begin
            ext_cnt_q <= `CNT_ZERO;
            ext_por_n_q <= `RST_ON;
        end else begin
            if (osc_rise) begin
                ext_cnt_q <= sat_inc(ext_cnt_q, `EXT_POR_CYCLES);
            end
            if (ext_cnt_q == `EXT_POR_CYCLES) begin
                ext_por_n_q <= `RST_OFF;
            end
        end
    end

    assign EXT_POR_N = ext_por_n_q;

    // Bus clock edges used by the later release phases
    assign bus_rise = bus_q & ~bus_dly_q;
    assign dly_fall = ~bus_dly_q & dly_prev_q;

    // Release phase sequencing
    always @* begin
        ph_d = ph_q;
        cnt_d = cnt_q;
        clkgen_d = clkgen_q;
        periph_d = periph_q;
        core_d = core_q;
        if (!comb_rst_n) begin
            ph_d = PH_HOLD;
            cnt_d = `CNT_ZERO;
            clkgen_d = `RST_ON;
            periph_d = `RST_ON;
            core_d = `RST_ON;
        end else begin
            case (ph_q)
                PH_HOLD: begin
                    // wait for the power-on stretch first
                    if (ext_por_n_q) begin
                        ph_d = PH_CLKGEN;
                        cnt_d = `CNT_ZERO;
                    end
                end
                PH_CLKGEN: begin
                    if (osc_rise) begin
                        cnt_d = sat_inc(cnt_q, `CLKGEN_DLY_CYCLES);
                    end
                    if ((cnt_q == `CLKGEN_DLY_CYCLES) && osc_fall) begin
                        clkgen_d = `RST_OFF;
                        ph_d = PH_PERIPH;
                        cnt_d = `CNT_ZERO;
                    end
                end
                PH_PERIPH: begin
                    if (bus_rise) begin
                        cnt_d = sat_inc(cnt_q, `PERIPH_DLY_CYCLES);
                    end
                    if ((cnt_q == `PERIPH_DLY_CYCLES) && dly_fall) begin
                        periph_d = `RST_OFF;
                        ph_d = PH_CORE;
                        cnt_d = `CNT_ZERO;
                    end
                end
                PH_CORE: begin
                    if (bus_rise) begin
                        cnt_d = sat_inc(cnt_q, `CORE_DLY_CYCLES);
                    end
                    // core waits for delayed clock fall
                    if ((cnt_q == `CORE_DLY_CYCLES) && dly_fall) begin
                        core_d = `RST_OFF;
                        ph_d = PH_RUN;
                        cnt_d = `CNT_ZERO;
                    end
                end
                PH_RUN: begin
                    ph_d = PH_RUN;
                end
                default: begin
                    ph_d = PH_HOLD;
                    cnt_d = `CNT_ZERO;
                end
            endcase
        end
    end

    // releases happen on a rising system clock edge
    always @(posedge SYSTEM_CLOCK or negedge arst_n) begin
        if (!arst_n) begin
            ph_q <= PH_HOLD;
            cnt_q <= `CNT_ZERO;
            clkgen_q <= `RST_ON;
            periph_q <= `RST_ON;
            core_q <= `RST_ON;
        end else begin
            ph_q <= ph_d;
            cnt_q <= cnt_d;
            clkgen_q <= clkgen_d;
            periph_q <= periph_d;
            core_q <= core_d;
        end
    end

    assign CLK_GEN_RST_N = clkgen_q;
    assign PERIPH_RST_N = periph_q;
    assign CORE_RST_N = core_q;

    assign pll_sel = (CLK_SRC_SEL == `SRC_PLL);
    // triple rate needs PLL powered and selected
    assign hs_ok = pll_sel & PLL_POWERED;

    // Clock dividers, held low while clock generation is in reset
    always @(posedge SYSTEM_CLOCK or negedge arst_n) begin
        if (!arst_n) begin
            fast_q <= `CLK_LOW;
            div3_q <= `DIV3_ZERO;
            x2_q <= `CLK_LOW;
            x2_prev_q <= `CLK_LOW;
            bus_q <= `CLK_LOW;
            bus_dly_q <= `CLK_LOW;
            dly_prev_q <= `CLK_LOW;
        end else if (!clkgen_q) begin
            fast_q <= `CLK_LOW;
            div3_q <= `DIV3_ZERO;
            x2_q <= `CLK_LOW;
            x2_prev_q <= `CLK_LOW;
            bus_q <= `CLK_LOW;
            bus_dly_q <= `CLK_LOW;
            dly_prev_q <= `CLK_LOW;
        end else begin
            // PLL over two, off on oscillator source
            if (!pll_sel) begin
                fast_q <= `CLK_LOW;
            end else if (pll_rise) begin
                fast_q <= ~fast_q;
            end
            if (pll_sel) begin
                if (pll_edge) begin
                    if (div3_q == `DIV3_LAST) begin
                        div3_q <= `DIV3_ZERO;
                        x2_q <= ~x2_q;
                    end else begin
                        div3_q <= div3_q + 2'h1;
                    end
                end
            end else begin
                div3_q <= `DIV3_ZERO;
                x2_q <= osc_q;
            end
            x2_prev_q <= x2_q;
            // bus clock is double-rate over two
            if (x2_q & ~x2_prev_q) begin
                bus_q <= ~bus_q;
            end
            bus_dly_q <= bus_q;
            dly_prev_q <= bus_dly_q;
        end
    end

    // stall conditions for core and peripheral groups
    assign core_run = ~(HOLDOFF_REQ | WAIT_MODE | STOP_MODE | CORE_CLK_DIS);
    assign periph_run = ~(STOP_MODE | PERIPH_CLK_DIS);

    // Gate enables change only while the bus clock is low
    always @(posedge SYSTEM_CLOCK or negedge arst_n) begin
        if (!arst_n) begin
            core_en_q <= `EN_OFF;
            periph_en_q <= `EN_OFF;
        end else if (!bus_q) begin
            core_en_q <= core_run;
            periph_en_q <= periph_run;
        end
    end

    // gated clocks, timer and PWM may run triple rate
    always @(posedge SYSTEM_CLOCK or negedge arst_n) begin
        if (!arst_n) begin
            core_clk_q <= `CLK_LOW;
            periph_clk_q <= `CLK_LOW;
            timer_clk_q <= `CLK_LOW;
            pwm_clk_q <= `CLK_LOW;
        end else begin
            core_clk_q <= bus_q & core_en_q;
            periph_clk_q <= bus_q & periph_en_q;
            timer_clk_q <= periph_en_q & pick_clk(TIMER_FAST_SEL, hs_ok, fast_q, bus_q);
            pwm_clk_q <= periph_en_q & pick_clk(PWM_FAST_SEL, hs_ok, fast_q, bus_q);
        end
    end

    // converter gets only its bus clock here
    assign ADC_BUS_CLK = periph_clk_q;
    assign FAST_CLK = fast_q;
    assign X2_CLK = x2_q;
    assign BUS_CLK = bus_q;
    assign BUS_CLK_DLY = bus_dly_q;
    assign CORE_CLK = core_clk_q;
    // Memory shares the core clock
    assign MEM_CLK = core_clk_q;
    assign PERIPH_CLK = periph_clk_q;
    assign TIMER_CLK = timer_clk_q;
    assign PWM_CLK = pwm_clk_q;

    // no interrupt output exists on this block
endmodule

// ### core/rst_clk_seq_defines.vh
// Constants for the reset and clock sequencer
`ifndef RST_CLK_SEQ_DEFINES_VH
`define RST_CLK_SEQ_DEFINES_VH

// Counter width for all release delays
`define CNT_W 7
// Extended power-on stretch, in master oscillator cycles
`define EXT_POR_CYCLES 7'd64
// Clock-generation release delay, in master oscillator cycles
`define CLKGEN_DLY_CYCLES 7'd32
// Peripheral release delay, in bus clock cycles
`define PERIPH_DLY_CYCLES 7'd32
// Core release delay, in bus clock cycles
`define CORE_DLY_CYCLES 7'd32
// Counter start value
`define CNT_ZERO 7'h00

// Clock source select encoding
`define SRC_PLL 1'b1
// PLL multiplier and rate ceilings (informative)
`define PLL_MULT 24
`define HS_CLK_MAX_MHZ 96
`define X2_CLK_MAX_MHZ 64
`define BUS_CLK_MAX_MHZ 32
// PLL edge counter for the divide-by-three
`define DIV3_W 2
`define DIV3_LAST 2'h2
`define DIV3_ZERO 2'h0

// Phase encoding width
`define PHASE_W 3

// Reset and clock levels
`define RST_ON 1'b0
`define RST_OFF 1'b1
`define CLK_LOW 1'b0
`define EN_OFF 1'b0

`endif

// ### core/reset_sync.v
// Two-stage reset synchroniser: asserts at once, releases on a clock edge
`timescale 1ns/1ps
module reset_sync (
    input wire clk,
    input wire arst_n,
    output wire rst_n_out
);
    reg meta_q;
    reg sync_q;

    // Second flop alone reads the first
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            meta_q <= 1'b0;
            sync_q <= 1'b0;
        end else begin
            meta_q <= 1'b1;
            sync_q <= meta_q;
        end
    end

    assign rst_n_out = sync_q;
endmodule

// ### verif/rcs_props.sv
// Concurrent checks on the reset and clock sequencer ports
`timescale 1ns/1ps
module rcs_props (
    input wire SYSTEM_CLOCK,
    input wire RSTN,
    input wire POR_N,
    input wire EXT_RST_N,
    input wire SW_RST_REQ,
    input wire WDOG_RST_N,
    input wire MASTER_OSC_IN,
    input wire CLK_SRC_SEL,
    input wire HOLDOFF_REQ,
    input wire WAIT_MODE,
    input wire STOP_MODE,
    input wire CORE_CLK_DIS,
    input wire PERIPH_CLK_DIS,
    input wire JTAG_RST_N,
    input wire EXT_POR_N,
    input wire CLK_GEN_RST_N,
    input wire PERIPH_RST_N,
    input wire CORE_RST_N,
    input wire FAST_CLK,
    input wire X2_CLK,
    input wire BUS_CLK,
    input wire BUS_CLK_DLY,
    input wire CORE_CLK,
    input wire PERIPH_CLK
);
    reg osc_q;
    reg [6:0] por_cnt;
    reg [7:0] cst_q;
    reg [7:0] pst_q;
    wire core_req = HOLDOFF_REQ | WAIT_MODE | STOP_MODE | CORE_CLK_DIS;
    wire per_req = STOP_MODE | PERIPH_CLK_DIS;
    default clocking @(posedge SYSTEM_CLOCK); endclocking
    default disable iff (!RSTN);
    // Oscillator rises since power-on release, and stall request lengths
    always @(posedge SYSTEM_CLOCK or negedge RSTN) begin
        if (!RSTN) begin
            osc_q <= 1'b0;
            por_cnt <= 7'h00;
            cst_q <= 8'h00;
            pst_q <= 8'h00;
        end else begin
            osc_q <= MASTER_OSC_IN;
            if (!POR_N)
                por_cnt <= 7'h00;
            else if (MASTER_OSC_IN && !osc_q && por_cnt != 7'h7f)
                por_cnt <= por_cnt + 7'h01;
            cst_q <= !core_req ? 8'h00 : (cst_q == 8'hff ? cst_q : cst_q + 8'h01);
            pst_q <= !per_req ? 8'h00 : (pst_q == 8'hff ? pst_q : pst_q + 8'h01);
        end
    end
    a_ext_por_len: assert property ($rose(EXT_POR_N) |-> por_cnt >= 7'h3f && por_cnt <= 7'h42)
        else $error("extended power-on length wrong");
    a_jtag_por_only: assert property ($fell(JTAG_RST_N) |-> !POR_N)
        else $error("test-access reset from non power-on source");
    a_sync_src_hit: assert property ((!WDOG_RST_N || SW_RST_REQ) |=>
        !CLK_GEN_RST_N && !PERIPH_RST_N && !CORE_RST_N) else $error("sync source missed");
    a_async_src_hit: assert property ((!EXT_RST_N || !POR_N) |->
        !CLK_GEN_RST_N && !PERIPH_RST_N && !CORE_RST_N && !BUS_CLK)
        else $error("async source missed");
    a_clkgen_all_off: assert property ($rose(CLK_GEN_RST_N) |-> EXT_POR_N && POR_N &&
        EXT_RST_N && WDOG_RST_N && !SW_RST_REQ) else $error("release with a source active");
    a_clkgen_osc_low: assert property ($rose(CLK_GEN_RST_N) |-> !MASTER_OSC_IN)
        else $error("clock-generation release not after oscillator fall");
    a_phase_order: assert property ($rose(CORE_RST_N) |-> PERIPH_RST_N && CLK_GEN_RST_N)
        else $error("core released out of order");
    a_periph_order: assert property ($rose(PERIPH_RST_N) |-> CLK_GEN_RST_N)
        else $error("peripheral released before clock generation");
    a_fast_off_osc: assert property ((!CLK_SRC_SEL)[*3] |-> !FAST_CLK)
        else $error("fast clock running on oscillator");
    a_bus_half_x2: assert property (CLK_GEN_RST_N && $rose(X2_CLK) |=>
        !CLK_GEN_RST_N || BUS_CLK != $past(BUS_CLK)) else $error("bus clock missed toggle");
    a_clk_hold_rst: assert property (!CLK_GEN_RST_N && !$past(CLK_GEN_RST_N) |->
        !X2_CLK && !FAST_CLK) else $error("dividers run in reset");
    a_dly_follows_bus: assert property (CLK_GEN_RST_N && $past(CLK_GEN_RST_N) |->
        BUS_CLK_DLY == $past(BUS_CLK)) else $error("delayed bus clock not one cycle late");
    a_release_dly_low: assert property ($rose(PERIPH_RST_N) || $rose(CORE_RST_N) |->
        !BUS_CLK_DLY && !BUS_CLK) else $error("release not in delayed clock low phase");
    a_core_stalled: assert property (cst_q > 8'h3c |-> !CORE_CLK)
        else $error("core clock not stalled");
    a_periph_stalled: assert property (pst_q > 8'h3c |-> !PERIPH_CLK)
        else $error("peripheral clock not stalled");
    c_core_out: cover property ($rose(CORE_RST_N));
    c_fast_run: cover property ($rose(FAST_CLK));
    c_core_stall: cover property (cst_q > 8'h3c);
endmodule
bind reset_and_clock_sequencer rcs_props u_props (.SYSTEM_CLOCK, .RSTN, .POR_N, .EXT_RST_N,
    .SW_RST_REQ, .WDOG_RST_N, .MASTER_OSC_IN, .CLK_SRC_SEL, .HOLDOFF_REQ, .WAIT_MODE,
    .STOP_MODE, .CORE_CLK_DIS, .PERIPH_CLK_DIS, .JTAG_RST_N, .EXT_POR_N, .CLK_GEN_RST_N,
    .PERIPH_RST_N, .CORE_RST_N, .FAST_CLK, .X2_CLK, .BUS_CLK, .BUS_CLK_DLY, .CORE_CLK,
    .PERIPH_CLK);

// ### verif/osc_pll_model.sv
// Model of the oscillator and PLL sources feeding the sequencer
`timescale 1ns/1ps
module osc_pll_model #(
    parameter int OSC_HALF = 4,
    parameter int PLL_HALF = 3
) (
    input wire clk,
    output reg osc = 1'b0,
    output reg pll = 1'b0
);
    int oc = 0;
    int pc = 0;
    // free-running oscillator
    // Both sources toggle through every reset; the PLL is slowed so levels can be sampled
    always @(posedge clk) begin
        oc <= (oc == OSC_HALF - 1) ? 0 : oc + 1;
        pc <= (pc == PLL_HALF - 1) ? 0 : pc + 1;
        if (oc == OSC_HALF - 1)
            osc <= ~osc;
        if (pc == PLL_HALF - 1)
            pll <= ~pll;
    end
endmodule

// ### verif/tb_top.sv
// Self-checking bench for the reset and clock sequencer
`timescale 1ns/1ps
`include "rst_clk_seq_defines.vh"
module tb_top;
    localparam int OH = 4;
    localparam int PH = 3;
    localparam int W = 720;
    reg SYSTEM_CLOCK = 1'b0;
    reg RSTN = 1'b0;
    reg POR_N = 1'b0;
    reg EXT_RST_N = 1'b1;
    reg SW_RST_REQ = 1'b0;
    reg WDOG_RST_N = 1'b1;
    reg CLK_SRC_SEL = 1'b1;
    reg PLL_POWERED = 1'b1;
    reg TIMER_FAST_SEL = 1'b0;
    reg PWM_FAST_SEL = 1'b0;
    reg [4:0] stall = 5'h00; // Hold-off, wait, stop, core off, peripheral off
    wire osc, pll, JTAG_RST_N, EXT_POR_N, CLK_GEN_RST_N, PERIPH_RST_N, CORE_RST_N;
    wire FAST_CLK, X2_CLK, BUS_CLK, CORE_CLK, MEM_CLK, PERIPH_CLK, ADC_BUS_CLK, TIMER_CLK, PWM_CLK;
    wire [10:0] sv = {PWM_CLK, TIMER_CLK, ADC_BUS_CLK, PERIPH_CLK, MEM_CLK, CORE_CLK, BUS_CLK,
        X2_CLK, FAST_CLK, pll, osc};
    wire [3:0] rs = {CORE_RST_N, PERIPH_RST_N, CLK_GEN_RST_N, EXT_POR_N};
    reg [10:0] pv = 11'h000;
    int rc[11];
    int base[11];
    int d[11];
    int errors = 0;
    int n_compared = 0;
    int cyc = 0;
    int seed;
    osc_pll_model #(.OSC_HALF(OH), .PLL_HALF(PH)) u_src (.clk(SYSTEM_CLOCK), .osc(osc), .pll(pll));
    reset_and_clock_sequencer uut (.SYSTEM_CLOCK, .RSTN, .POR_N, .EXT_RST_N, .SW_RST_REQ, .WDOG_RST_N,
        .MASTER_OSC_IN(osc), .PLL_CLK_IN(pll), .CLK_SRC_SEL, .PLL_POWERED, .TIMER_FAST_SEL,
        .PWM_FAST_SEL, .HOLDOFF_REQ(stall[4]), .WAIT_MODE(stall[3]), .STOP_MODE(stall[2]),
        .CORE_CLK_DIS(stall[1]), .PERIPH_CLK_DIS(stall[0]), .JTAG_RST_N, .EXT_POR_N,
        .CLK_GEN_RST_N, .PERIPH_RST_N, .CORE_RST_N, .FAST_CLK, .X2_CLK, .BUS_CLK, .BUS_CLK_DLY(),
        .CORE_CLK, .MEM_CLK, .PERIPH_CLK, .ADC_BUS_CLK, .TIMER_CLK, .PWM_CLK);
    always #5 SYSTEM_CLOCK = ~SYSTEM_CLOCK;
    // Rising-edge counters for every clock but BUS_CLK_DLY, and the run limit
    always @(posedge SYSTEM_CLOCK) begin
        pv <= sv;
        cyc <= cyc + 1;
        for (int i = 0; i < 11; i++) begin
            if (sv[i] && !pv[i])
                rc[i] <= rc[i] + 1;
        end
        if (cyc == 50000) begin
            errors = errors + 1;
            results;
        end
    end
    function automatic int rises(input int half);
        return W / (2 * half);
    endfunction
    task results;
        if (errors == 0 && n_compared > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    task chk(input int got, input int exp, input int tol);
        n_compared++;
        if (got < exp - tol || got > exp + tol) begin
            errors++;
            $display("unexpected at %0t: got %h exp %h", $time, got, exp);
        end
    endtask
    task chkb(input logic got, input logic exp);
        n_compared++;
        if (got !== exp) begin
            errors++;
            $display("unexpected at %0t: got %h exp %h", $time, got, exp);
        end
    endtask
    task tick(input int n);
        repeat (n) @(posedge SYSTEM_CLOCK);
    endtask
    task win;
        base = rc;
        tick(W);
        for (int i = 0; i < 11; i++)
            d[i] = rc[i] - base[i];
    endtask
    task wait_hi(input int k);
        int t;
        t = 0;
        while (rs[k] !== 1'b1 && t < 5000) begin
            tick(1);
            t++;
        end
        // A release that never comes counts as a mismatch
        chkb(rs[k], 1'b1);
    endtask
    // Phased release, counted in oscillator and bus clock rises
    task seq(input bit por);
        int s;
        if (por) begin
            s = rc[0];
            wait_hi(0);
            chk(rc[0] - s, `EXT_POR_CYCLES, 2);
        end
        s = rc[0];
        wait_hi(1);
        chk(rc[0] - s, `CLKGEN_DLY_CYCLES, 2);
        s = rc[4];
        wait_hi(2);
        chk(rc[4] - s, `PERIPH_DLY_CYCLES, 2);
        s = rc[4];
        wait_hi(3);
        chk(rc[4] - s, `CORE_DLY_CYCLES, 2);
    endtask
    // One clock configuration, rises compared over a window
    task clk_case(input bit sel, input bit tf, input bit pf, input bit pw, input [4:0] st);
        int fe, be;
        bit cs, ps;
        CLK_SRC_SEL <= sel;
        TIMER_FAST_SEL <= tf;
        PWM_FAST_SEL <= pf;
        PLL_POWERED <= pw;
        stall <= st;
        tick(60);
        win;
        fe = sel ? rises(2 * PH) : 0;
        be = (sel ? rises(3 * PH) : rises(OH)) / 2;
        cs = st[4] | st[3] | st[2] | st[1];
        ps = st[2] | st[0];
        chk(d[2], fe, 1);
        chk(d[3], 2 * be, 1);
        chk(d[4], be, 1);
        chk(d[5], cs ? 0 : be, 1);
        chk(d[6], cs ? 0 : be, 1);
        chk(d[7], ps ? 0 : be, 1);
        chk(d[8], ps ? 0 : be, 1);
        chk(d[9], ps ? 0 : (tf && pw && sel ? fe : be), 1);
        chk(d[10], ps ? 0 : (pf && pw && sel ? fe : be), 1);
    endtask
    // Main sequence
    initial begin
        seed = $urandom(32'h4f946f4e);
        tick(10);
        RSTN <= 1'b1;
        tick(3);
        POR_N <= 1'b1;
        seq(1);
        chkb(JTAG_RST_N, 1'b1);
        clk_case(1, 1, 0, 1, 5'h00);
        clk_case(1, 1, 1, 0, 5'h00);
        clk_case(0, 1, 1, 1, 5'h00);
        for (int i = 0; i < 5; i++)
            clk_case(1, 1, 0, 1, 5'h01 << i);
        repeat (4)
            clk_case($urandom % 2, $urandom % 2, $urandom % 2, $urandom % 2, $urandom % 32);
        clk_case(1, 0, 0, 1, 5'h00);
        EXT_RST_N <= 1'b0;
        tick(2);
        chkb(CLK_GEN_RST_N, 1'b0);
        win;
        chk(d[4], 0, 0);
        chk(d[3], 0, 0);
        chkb(JTAG_RST_N, 1'b1);
        chkb(EXT_POR_N, 1'b1);
        EXT_RST_N <= 1'b1;
        seq(0);
        for (int k = 0; k < 2; k++) begin
            WDOG_RST_N <= (k != 0);
            SW_RST_REQ <= (k != 0);
            tick(1 + $urandom % 3);
            WDOG_RST_N <= 1'b1;
            SW_RST_REQ <= 1'b0;
            tick(1);
            chkb(CORE_RST_N, 1'b0);
            seq(0);
        end
        EXT_RST_N <= 1'b0;
        tick(2);
        EXT_RST_N <= 1'b1;
        wait_hi(1);
        tick(200);
        WDOG_RST_N <= 1'b0;
        tick(1);
        WDOG_RST_N <= 1'b1;
        tick(1);
        chkb(CLK_GEN_RST_N, 1'b0);
        seq(0);
        // Power-on drops alone first, so the test-access reset falls while RSTN is still high
        POR_N <= 1'b0;
        tick(1);
        RSTN <= 1'b0;
        tick(2);
        chkb(JTAG_RST_N, 1'b0);
        chkb(EXT_POR_N, 1'b0);
        RSTN <= 1'b1;
        tick(3);
        POR_N <= 1'b1;
        seq(1);
        results;
    end
endmodule
